// >>> crf_core.sv
// Architectural register file of a small 32-bit processor core
// Function
// - sixteen 32-bit architectural registers
// - upper general registers need restricted instructions
// - two stack pointers, one visible
// - thread mode: select bit picks stack
// - reset loads main stack from address zero
// - reset loads counter from address four
// - vector bit zero becomes state bit
// - link register holds return information
// - writing counter redirects program flow
// - status word holds three disjoint views
// - flags sit in bits 31 to 28
// - flags follow results, readable and writable
// - executing with state bit clear faults
// - low six bits hold handler number
// - mask bit blocks configurable exceptions
// - select register resets zero, thread only
// - handlers always use main stack
// - handler writes to select register ignored
module crf_core
  import crf_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Reset vector fetch
  output logic                   vec_req_o,
  output logic      [DATA_W-1:0] vec_addr_o,
  input  wire logic              vec_valid_i,
  input  wire logic [DATA_W-1:0] vec_rdata_i,
  output logic                   core_ready_o,
  // Operand reads
  input  wire logic [3:0]        rd_a_idx_i,
  input  wire logic [3:0]        rd_b_idx_i,
  input  wire logic              rd_hi_ok_i,
  output logic      [DATA_W-1:0] rd_a_data_o,
  output logic      [DATA_W-1:0] rd_b_data_o,
  // Register write
  input  wire logic              wr_en_i,
  input  wire logic [3:0]        wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_hi_ok_i,
  output logic                   access_err_o,
  // Program counter
  input  wire logic              pc_adv_i,
  input  wire logic [DATA_W-1:0] pc_next_i,
  output logic      [DATA_W-1:0] pc_o,
  output logic                   redirect_o,
  // Condition flags
  input  wire logic              flag_wr_i,
  input  wire logic [3:0]        flag_nzcv_i,
  // Special registers
  input  wire logic              spec_wr_i,
  input  wire logic [2:0]        spec_sel_i,
  input  wire logic [DATA_W-1:0] spec_wdata_i,
  output logic      [DATA_W-1:0] spec_rdata_o,
  input  wire logic              mask_set_i,
  input  wire logic              mask_clr_i,
  // Exceptions
  input  wire logic              exc_entry_i,
  input  wire logic [EXC_W-1:0]  exc_num_i,
  input  wire logic              exc_return_i,
  input  wire logic [EXC_W-1:0]  exc_ret_num_i,
  input  wire logic              exc_ret_spsel_i,
  input  wire logic              exc_cfg_req_i,
  output logic                   exc_cfg_allow_o,
  input  wire logic              instr_issue_i,
  output logic                   severe_fault_o,
  // State view
  output logic      [DATA_W-1:0] status_word_o,
  output logic                   handler_mode_o,
  output logic      [DATA_W-1:0] active_sp_o
);

  crf_state_t        state_q;
  logic [DATA_W-1:0] pc_q;
  logic [DATA_W-1:0] link_q;
  logic [3:0]        flags_q;
  logic              tbit_q;
  logic [EXC_W-1:0]  exc_q;
  logic              mask_q;
  logic              spsel_q;
  logic              run;
  logic              handler;
  logic              use_proc;
  logic              wr_ok;
  logic              spec_ok;
  logic              redirect_q;
  logic              fault_q;
  logic              err_q;
  logic [DATA_W-1:0] rd_a_q;
  logic [DATA_W-1:0] rd_b_q;
  logic [DATA_W-1:0] spec_q;
  logic [DATA_W-1:0] gpr_a;
  logic [DATA_W-1:0] gpr_b;
  logic [DATA_W-1:0] main_sp;
  logic [DATA_W-1:0] proc_sp;
  logic [DATA_W-1:0] sp;

  // Upper general registers are reachable only by the restricted subset
  function automatic logic is_upper(input logic [3:0] idx);
    is_upper = (idx >= IDX_LOW_END) && (idx < IDX_SP);
  endfunction

  // Operand value for one architectural index
  function automatic logic [DATA_W-1:0] reg_value(
    input logic [3:0]        idx,
    input logic              hi_ok,
    input logic [DATA_W-1:0] gpr,
    input logic [DATA_W-1:0] sp_v,
    input logic [DATA_W-1:0] link_v,
    input logic [DATA_W-1:0] pc_v
  );
    logic [DATA_W-1:0] v;
    v = gpr;
    if (is_upper(idx) && !hi_ok)
      v = WORD_RST;
    else if (idx == IDX_SP)
      v = sp_v;
    else if (idx == IDX_LINK)
      v = link_v;
    else if (idx == IDX_PC)
      v = pc_v;
    reg_value = v;
  endfunction

  assign run            = (state_q == ST_RUN);
  assign handler        = (exc_q != EXC_RST);
  assign core_ready_o   = run;
  assign handler_mode_o = handler;
  assign active_sp_o    = sp;
  assign pc_o           = pc_q;
  assign redirect_o     = redirect_q;
  assign severe_fault_o = fault_q;
  assign access_err_o   = err_q;
  assign rd_a_data_o    = rd_a_q;
  assign rd_b_data_o    = rd_b_q;
  assign spec_rdata_o   = spec_q;
  assign wr_ok          = run && wr_en_i && !(is_upper(wr_idx_i) && !wr_hi_ok_i);
  assign spec_ok        = run && spec_wr_i;

  // Three disjoint views packed into one word
  assign status_word_o = {flags_q, {RSV_HI_W{1'b0}}, tbit_q,
                          {RSV_LO_W{1'b0}}, exc_q};

  // Configurable exceptions only; fixed-priority ones bypass the mask
  assign exc_cfg_allow_o = exc_cfg_req_i && !mask_q;

  // Reset sequence: stack word first, then entry vector
  assign vec_req_o  = (state_q == ST_SP) || (state_q == ST_PC);
  assign vec_addr_o = (state_q == ST_PC) ? PC_VEC_ADDR : SP_VEC_ADDR;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      state_q <= ST_START;
    else
    begin
      case (state_q)
        ST_START: state_q <= ST_SP;
        ST_SP:    state_q <= vec_valid_i ? ST_PC : ST_SP;
        ST_PC:    state_q <= vec_valid_i ? ST_RUN : ST_PC;
        ST_RUN:   state_q <= ST_RUN;
        default:  state_q <= ST_START;
      endcase
    end
  end

  crf_gpr_bank u_gpr (
    .mclk_i      (mclk_i),
    .wr_en_i     (wr_ok),
    .wr_idx_i    (wr_idx_i),
    .wr_data_i   (wr_data_i),
    .rd_a_idx_i  (rd_a_idx_i),
    .rd_b_idx_i  (rd_b_idx_i),
    .rd_a_data_o (gpr_a),
    .rd_b_data_o (gpr_b)
  );

  crf_stack_sel u_sp (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .handler_i   (handler),
    .spsel_i     (spsel_q),
    .wr_active_i (wr_ok && (wr_idx_i == IDX_SP)),
    .wr_main_i   ((state_q == ST_SP && vec_valid_i) || (spec_ok && spec_sel_i == SEL_MAIN_SP)),
    .wr_proc_i   (spec_ok && spec_sel_i == SEL_PROC_SP),
    .wr_data_i   (vec_req_o ? vec_rdata_i : (spec_ok && spec_sel_i inside {SEL_MAIN_SP,
                  SEL_PROC_SP}) ? spec_wdata_i : wr_data_i),
    .use_proc_o  (use_proc),
    .active_sp_o (sp),
    .main_sp_o   (main_sp),
    .proc_sp_o   (proc_sp)
  );

  // Program counter: vector load, explicit write, then sequential advance
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pc_q       <= WORD_RST;
      redirect_q <= 1'b0;
    end
    else
    begin
      redirect_q <= wr_ok && (wr_idx_i == IDX_PC);
      if (state_q == ST_PC && vec_valid_i)
        pc_q <= {vec_rdata_i[DATA_W-1:1], 1'b0};
      else if (wr_ok && (wr_idx_i == IDX_PC))
        pc_q <= {wr_data_i[DATA_W-1:1], 1'b0};
      else if (run && pc_adv_i)
        pc_q <= pc_next_i;
    end
  end

  // State bit is only ever set from the entry vector
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      tbit_q <= 1'b0;
    else if (state_q == ST_PC && vec_valid_i)
      tbit_q <= vec_rdata_i[0];
  end

  // Return address is written by the pipeline on calls and entry
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      link_q <= WORD_RST;
    else if (wr_ok && (wr_idx_i == IDX_LINK))
      link_q <= wr_data_i;
  end

  // Status writes touch the flags only; other views are read-only
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      flags_q <= FLAGS_RST;
    else if (spec_ok && spec_sel_i == SEL_STATUS)
      flags_q <= spec_wdata_i[FLAG_N_BIT:FLAG_V_BIT];
    else if (run && flag_wr_i)
      flags_q <= flag_nzcv_i;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      exc_q <= EXC_RST;
    else if (run && exc_entry_i)
      exc_q <= exc_num_i;
    else if (run && exc_return_i)
      exc_q <= exc_ret_num_i;
  end

  // Clearing wins over setting when both arrive together
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      mask_q <= 1'b0;
    else if (spec_ok && spec_sel_i == SEL_MASK)
      mask_q <= spec_wdata_i[MASK_BIT];
    else if (run && mask_clr_i)
      mask_q <= 1'b0;
    else if (run && mask_set_i)
      mask_q <= 1'b1;
  end

  // Entry forces the main stack; return restores the thread choice
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      spsel_q <= 1'b0;
    else if (run && exc_entry_i)
      spsel_q <= 1'b0;
    else if (run && exc_return_i)
      spsel_q <= exc_ret_spsel_i;
    else if (spec_ok && spec_sel_i == SEL_CTRL && !handler)
      spsel_q <= spec_wdata_i[SPSEL_BIT];
  end

  // Registered read data, one cycle after the index
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_a_q <= WORD_RST;
      rd_b_q <= WORD_RST;
      err_q  <= 1'b0;
    end
    else
    begin
      rd_a_q <= reg_value(rd_a_idx_i, rd_hi_ok_i, gpr_a, sp, link_q, pc_q);
      rd_b_q <= reg_value(rd_b_idx_i, rd_hi_ok_i, gpr_b, sp, link_q, pc_q);
      err_q  <= run && wr_en_i && is_upper(wr_idx_i) && !wr_hi_ok_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      spec_q <= WORD_RST;
    else
      case (spec_sel_i)
        SEL_STATUS:  spec_q <= status_word_o;
        SEL_MAIN_SP: spec_q <= main_sp;
        SEL_PROC_SP: spec_q <= proc_sp;
        SEL_MASK:    spec_q <= {31'h0000_0000, mask_q};
        SEL_CTRL:    spec_q <= {30'h0000_0000, spsel_q, 1'b0};
        default:     spec_q <= WORD_RST;
      endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      fault_q <= 1'b0;
    else
      fault_q <= run && instr_issue_i && !tbit_q;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  sequence sp_fetch_s;
    (state_q == ST_SP) && vec_valid_i;
  endsequence

  sequence pc_fetch_s;
    (state_q == ST_PC) && vec_valid_i;
  endsequence

  main_vector_a: assert property (sp_fetch_s |=> main_sp == $past(vec_rdata_i)
    && state_q == ST_PC) else $error("main stack not loaded from vector");
  pc_vector_a: assert property (pc_fetch_s |=> run
    && pc_q == {$past(vec_rdata_i[31:1]), 1'b0}) else $error("counter not loaded");
  tbit_load_a: assert property (pc_fetch_s |=> tbit_q == $past(vec_rdata_i[0]))
    else $error("state bit not taken from vector");
  state_fault_a: assert property (run && instr_issue_i && !tbit_q
    |=> severe_fault_o ##1 !severe_fault_o || $past(instr_issue_i))
    else $error("missing fault on clear state bit");
  mask_gate_a: assert property (exc_cfg_allow_o |-> !mask_q && exc_cfg_req_i)
    else $error("masked exception allowed");
  handler_stack_a: assert property (handler |-> sp == main_sp && !use_proc)
    else $error("handler not on main stack");
  thread_stack_a: assert property (!handler && spsel_q |-> sp == proc_sp)
    else $error("thread select ignored");
  ctrl_ignore_a: assert property (spec_ok && spec_sel_i == SEL_CTRL && handler
    && !exc_entry_i && !exc_return_i |=> $stable(spsel_q))
    else $error("select written in handler");
  ro_views_a: assert property (spec_ok && spec_sel_i == SEL_STATUS && !exc_entry_i
    && !exc_return_i |=> $stable(exc_q) && $stable(tbit_q)
    && flags_q == $past(spec_wdata_i[31:28])) else $error("read-only view changed");
  pc_redirect_a: assert property (wr_ok && wr_idx_i == IDX_PC
    |=> redirect_o && pc_o == {$past(wr_data_i[31:1]), 1'b0})
    else $error("counter write did not redirect");
  upper_refuse_a: assert property (run && wr_en_i && is_upper(wr_idx_i) && !wr_hi_ok_i
    |=> access_err_o ##1 !access_err_o || $past(wr_en_i)) else $error("upper access not refused");

endmodule

// >>> crf_pkg.sv
// Shared constants and types for the core register file
package crf_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_GPR   = 13;

  // Register indices as seen by instructions
  localparam logic [3:0]  IDX_LOW_END = 4'h8;
  localparam logic [3:0]  IDX_SP      = 4'hd;
  localparam logic [3:0]  IDX_LINK    = 4'he;
  localparam logic [3:0]  IDX_PC      = 4'hf;

  // Vector table words fetched at reset
  localparam logic [31:0] SP_VEC_ADDR = 32'h0000_0000;
  localparam logic [31:0] PC_VEC_ADDR = 32'h0000_0004;

  // Combined status word field positions
  localparam int unsigned FLAG_N_BIT  = 31;
  localparam int unsigned FLAG_V_BIT  = 28;
  localparam int unsigned TBIT_POS    = 24;
  localparam int unsigned EXC_W       = 6;
  localparam int unsigned RSV_HI_W    = 3;
  localparam int unsigned RSV_LO_W    = 18;

  // Control bit positions
  localparam int unsigned SPSEL_BIT   = 1;
  localparam int unsigned MASK_BIT    = 0;

  // Reset values
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;
  localparam logic [5:0]  EXC_RST     = 6'h00;

  // Special register selector codes
  localparam logic [2:0]  SEL_STATUS  = 3'h0;
  localparam logic [2:0]  SEL_MAIN_SP = 3'h1;
  localparam logic [2:0]  SEL_PROC_SP = 3'h2;
  localparam logic [2:0]  SEL_MASK    = 3'h3;
  localparam logic [2:0]  SEL_CTRL    = 3'h4;

  typedef enum logic [3:0] {
    ST_START = 4'b0001,
    ST_SP    = 4'b0010,
    ST_PC    = 4'b0100,
    ST_RUN   = 4'b1000
  } crf_state_t;

endpackage

// >>> crf_gpr_bank.sv
// General-purpose register array with two read ports and one write port
module crf_gpr_bank
  import crf_pkg::*;
(
  // Clock
  input  wire logic              mclk_i,
  // Write port
  input  wire logic              wr_en_i,
  input  wire logic [3:0]        wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // Read ports
  input  wire logic [3:0]        rd_a_idx_i,
  input  wire logic [3:0]        rd_b_idx_i,
  output logic      [DATA_W-1:0] rd_a_data_o,
  output logic      [DATA_W-1:0] rd_b_data_o
);

  // Contents are undefined after reset, so the array carries no reset
  logic [DATA_W-1:0] gpr_q [NUM_GPR];

  always_ff @(posedge mclk_i)
  begin
    if (wr_en_i && (wr_idx_i < 4'(NUM_GPR)))
    begin
      gpr_q[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_a_data_o = (rd_a_idx_i < 4'(NUM_GPR)) ? gpr_q[rd_a_idx_i] : WORD_RST;
  assign rd_b_data_o = (rd_b_idx_i < 4'(NUM_GPR)) ? gpr_q[rd_b_idx_i] : WORD_RST;

endmodule

// >>> crf_stack_sel.sv
// Banked main and process stack pointers with mode-dependent selection
module crf_stack_sel
  import crf_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Mode
  input  wire logic              handler_i,
  input  wire logic              spsel_i,
  // Writes
  input  wire logic              wr_active_i,
  input  wire logic              wr_main_i,
  input  wire logic              wr_proc_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // State
  output logic                   use_proc_o,
  output logic      [DATA_W-1:0] active_sp_o,
  output logic      [DATA_W-1:0] main_sp_o,
  output logic      [DATA_W-1:0] proc_sp_o
);

  logic [DATA_W-1:0] main_sp_q;
  logic [DATA_W-1:0] proc_sp_q;

  // Handler code always runs on the main stack
  assign use_proc_o  = !handler_i && spsel_i;
  assign active_sp_o = use_proc_o ? proc_sp_q : main_sp_q;
  assign main_sp_o   = main_sp_q;
  assign proc_sp_o   = proc_sp_q;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      main_sp_q <= WORD_RST;
    end
    else if (wr_main_i || (wr_active_i && !use_proc_o))
    begin
      main_sp_q <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      proc_sp_q <= WORD_RST;
    end
    else if (wr_proc_i || (wr_active_i && use_proc_o))
    begin
      proc_sp_q <= wr_data_i;
    end
  end

endmodule

// >>> crf_vec_mem.sv
// Vector table memory model answering the reset-time fetches of the register file
module crf_vec_mem
  import crf_pkg::*;
#(
  parameter logic [31:0] SP_INIT = 32'h2000_1000,
  parameter logic [31:0] PC_INIT = 32'h0000_0101
)
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Fetch port
  input  wire logic              vec_req_i,
  input  wire logic [DATA_W-1:0] vec_addr_i,
  output logic                   vec_valid_o,
  output logic      [DATA_W-1:0] vec_rdata_o,
  // Scenario control: store the reset vector with its state bit clear
  input  wire logic              bad_tbit_i
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned       wait_q;
  logic [DATA_W-1:0] word;

  // Bit 0 of the stored reset vector is set unless a scenario asks otherwise
  assign word = (vec_addr_i == SP_VEC_ADDR) ? SP_INIT :
                (vec_addr_i == PC_VEC_ADDR) ? {PC_INIT[31:1], !bad_tbit_i} : ~SP_INIT;

  // Random latency, so the fetch is answered both promptly and slowly
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      vec_valid_o <= 1'b0;
      wait_q      <= 0;
    end
    else if (vec_valid_o || !vec_req_i)
    begin
      vec_valid_o <= 1'b0;
      wait_q      <= $urandom_range(3, 0);
    end
    else if (wait_q != 0)
      wait_q <= wait_q - 1;
    else
      vec_valid_o <= 1'b1;
  end

  // Outside the answer cycle the data lines toggle, so stale words never look valid
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      vec_rdata_o <= 32'h0000_0000;
    else if (vec_req_i && !vec_valid_o && wait_q == 0)
      vec_rdata_o <= word;
    else
      vec_rdata_o <= ~vec_rdata_o;
  end
endmodule

// >>> crf_tb.sv
// Self-checking bench for the core register file
module testbench
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] SP_INIT = 32'h2000_1000;
  localparam logic [31:0] PC_INIT = 32'h0000_0101;

  typedef struct {
    int          due;
    int          kind;
    logic [31:0] exp;
  } crf_note_t;

  logic        mclk_i        = 1'b0;
  logic        reset_i       = 1'b1;
  logic        bad_tbit      = 1'b0;
  logic [3:0]  rd_a_idx_i    = 4'h0;
  logic [3:0]  rd_b_idx_i    = 4'h0;
  logic        rd_hi_ok_i    = 1'b0;
  logic        wr_en_i       = 1'b0;
  logic [3:0]  wr_idx_i      = 4'h0;
  logic [31:0] wr_data_i     = 32'h0000_0000;
  logic        wr_hi_ok_i    = 1'b0;
  logic [31:0] pc_next_i     = 32'h0000_0000;
  logic [3:0]  flag_nzcv_i   = 4'h0;
  logic        spec_wr_i     = 1'b0;
  logic [2:0]  spec_sel_i    = 3'h0;
  logic [31:0] spec_wdata_i  = 32'h0000_0000;
  logic [6:0]  pls           = 7'h00;
  logic [5:0]  exc_num_i     = 6'h00;
  logic [5:0]  exc_ret_num_i = 6'h00;
  logic        exc_ret_spsel_i = 1'b0;
  logic        exc_cfg_req_i = 1'b0;
  logic        vec_valid_i;
  logic        vec_req_o;
  logic        core_ready_o;
  logic        access_err_o;
  logic        redirect_o;
  logic        exc_cfg_allow_o;
  logic        severe_fault_o;
  logic        handler_mode_o;
  logic [31:0] vec_rdata_i;
  logic [31:0] vec_addr_o;
  logic [31:0] rd_a_data_o;
  logic [31:0] rd_b_data_o;
  logic [31:0] pc_o;
  logic [31:0] spec_rdata_o;
  logic [31:0] status_word_o;
  logic [31:0] active_sp_o;
  int          cyc;
  int          num_errors;
  int          total_checks;
  crf_note_t   exp_q[$];
  crf_note_t   nt;

  crf_vec_mem #(.SP_INIT(SP_INIT), .PC_INIT(PC_INIT)) u_crf_vec_mem (
    .mclk_i, .reset_i, .vec_req_i(vec_req_o), .vec_addr_i(vec_addr_o),
    .vec_valid_o(vec_valid_i), .vec_rdata_o(vec_rdata_i), .bad_tbit_i(bad_tbit));

  crf_core u_crf_core (
    .mclk_i, .reset_i, .vec_req_o, .vec_addr_o, .vec_valid_i, .vec_rdata_i, .core_ready_o,
    .rd_a_idx_i, .rd_b_idx_i, .rd_hi_ok_i, .rd_a_data_o, .rd_b_data_o,
    .wr_en_i, .wr_idx_i, .wr_data_i, .wr_hi_ok_i, .access_err_o,
    .pc_adv_i(pls[5]), .pc_next_i, .pc_o, .redirect_o,
    .flag_wr_i(pls[6]), .flag_nzcv_i,
    .spec_wr_i, .spec_sel_i, .spec_wdata_i, .spec_rdata_o,
    .mask_set_i(pls[0]), .mask_clr_i(pls[1]),
    .exc_entry_i(pls[2]), .exc_num_i, .exc_return_i(pls[3]), .exc_ret_num_i,
    .exc_ret_spsel_i, .exc_cfg_req_i, .exc_cfg_allow_o,
    .instr_issue_i(pls[4]), .severe_fault_o,
    .status_word_o, .handler_mode_o, .active_sp_o);

  initial
    forever #5 mclk_i = ~mclk_i;

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] seen(int kind);
    case (kind)
      0: return rd_a_data_o;
      1: return rd_b_data_o;
      2: return spec_rdata_o;
      3: return pc_o;
      4: return status_word_o;
      5: return active_sp_o;
      6: return {31'h0, severe_fault_o};
      7: return {31'h0, access_err_o};
      8: return {31'h0, redirect_o};
      9: return {31'h0, exc_cfg_allow_o};
      10: return {31'h0, handler_mode_o};
      default: return {31'h0, core_ready_o};
    endcase
  endfunction

  function automatic logic [31:0] stw(logic [3:0] f, logic t, logic [5:0] e);
    return {f, 3'h0, t, 18'h0_0000, e};
  endfunction

  // Notes are due d falling edges on; a note made after an edge with d=1 sees that edge
  task automatic put(int kind, logic [31:0] e, int d);
    exp_q.push_back('{cyc + d, kind, e});
  endtask

  always @(negedge mclk_i)
  begin
    cyc++;
    while (exp_q.size() > 0 && exp_q[0].due <= cyc)
    begin
      nt = exp_q.pop_front();
      chk(seen(nt.kind), nt.exp);
    end
  end

  task automatic do_reset(logic bad);
    // Two edges first, so reads noted just before reset are checked before it clears them
    repeat (2) @(posedge mclk_i);
    reset_i  <= 1'b1;
    bad_tbit <= bad;
    repeat (12) @(posedge mclk_i);
    put(11, 32'h0, 1);
    reset_i <= 1'b0;
    for (int i = 0; i < 40 && core_ready_o !== 1'b1; i++)
      @(negedge mclk_i);
    @(posedge mclk_i);
    put(11, 32'h1, 1);
  endtask

  task automatic wreg(logic [3:0] idx, logic [31:0] d, logic hi);
    @(posedge mclk_i);
    wr_en_i    <= 1'b1;
    wr_idx_i   <= idx;
    wr_data_i  <= d;
    wr_hi_ok_i <= hi;
    put(7, {31'h0, (idx inside {[4'h8:4'hc]}) && !hi}, 2);
    put(8, {31'h0, idx == IDX_PC}, 2);
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rreg(logic [3:0] idx, logic hi, logic [31:0] e);
    @(posedge mclk_i);
    rd_a_idx_i <= idx;
    rd_b_idx_i <= idx;
    rd_hi_ok_i <= hi;
    put(0, e, 2);
    put(1, e, 2);
  endtask

  task automatic spw(logic [2:0] sel, logic [31:0] d);
    @(posedge mclk_i);
    spec_wr_i    <= 1'b1;
    spec_sel_i   <= sel;
    spec_wdata_i <= d;
    @(posedge mclk_i);
    spec_wr_i <= 1'b0;
  endtask

  task automatic spr(logic [2:0] sel, logic [31:0] e);
    @(posedge mclk_i);
    spec_sel_i <= sel;
    put(2, e, 2);
  endtask

  task automatic pulse(logic [6:0] m);
    @(posedge mclk_i);
    pls <= m;
    @(posedge mclk_i);
    pls <= 7'h00;
  endtask

  initial
  begin
    #200_000;
    num_errors++;
    summarize();
  end

  initial
  begin
    logic [31:0] d [13];
    logic [3:0]  f;
    void'($urandom(32'hd900));
    do_reset(1'b0);
    put(5, SP_INIT, 1);
    put(3, {PC_INIT[31:1], 1'b0}, 1);
    put(4, stw(4'h0, 1'b1, 6'h00), 1);
    spr(SEL_CTRL, 32'h0000_0000);
    spr(SEL_MASK, 32'h0000_0000);
    for (int i = 0; i < NUM_GPR; i++)
    begin
      d[i] = $urandom;
      wreg(i[3:0], d[i], i >= 8);
    end
    for (int i = 0; i < NUM_GPR; i++)
      rreg(i[3:0], 1'b1, d[i]);
    wreg(4'h9, ~d[9], 1'b0);
    rreg(4'h9, 1'b1, d[9]);
    rreg(4'ha, 1'b0, 32'h0000_0000);
    wreg(IDX_LINK, d[0], 1'b0);
    rreg(IDX_LINK, 1'b0, d[0]);
    wreg(IDX_PC, d[1], 1'b0);
    put(3, {d[1][31:1], 1'b0}, 1);
    pc_next_i <= {d[2][31:1], 1'b0};
    pulse(7'h20);
    put(3, {d[2][31:1], 1'b0}, 1);
    f = 4'($urandom);
    flag_nzcv_i <= f;
    pulse(7'h40);
    put(4, stw(f, 1'b1, 6'h00), 1);
    spw(SEL_STATUS, 32'hffff_ffff);
    put(4, stw(4'hf, 1'b1, 6'h00), 1);
    spr(SEL_STATUS, stw(4'hf, 1'b1, 6'h00));
    pulse(7'h10);
    put(6, 32'h0000_0000, 1);
    wreg(IDX_SP, d[3], 1'b0);
    spw(SEL_PROC_SP, d[4]);
    spr(SEL_MAIN_SP, d[3]);
    spw(SEL_CTRL, 32'h0000_0002);
    put(5, d[4], 1);
    wreg(IDX_SP, d[5], 1'b0);
    spr(SEL_PROC_SP, d[5]);
    spr(SEL_MAIN_SP, d[3]);
    exc_num_i <= 6'h05;
    pulse(7'h04);
    put(10, 32'h0000_0001, 1);
    put(5, d[3], 1);
    put(4, stw(4'hf, 1'b1, 6'h05), 1);
    spw(SEL_CTRL, 32'h0000_0002);
    spr(SEL_CTRL, 32'h0000_0000);
    exc_ret_spsel_i <= 1'b1;
    pulse(7'h08);
    put(10, 32'h0000_0000, 1);
    put(5, d[5], 1);
    spr(SEL_CTRL, 32'h0000_0002);
    exc_cfg_req_i <= 1'b1;
    pulse(7'h01);
    put(9, 32'h0000_0000, 1);
    pulse(7'h03);
    put(9, 32'h0000_0001, 1);
    spw(SEL_MASK, 32'h0000_0001);
    put(9, 32'h0000_0000, 1);
    spr(SEL_MASK, 32'h0000_0001);
    // Second reset in mid-run, this time with a vector whose state bit is clear
    do_reset(1'b1);
    put(4, stw(4'h0, 1'b0, 6'h00), 1);
    pulse(7'h10);
    put(6, 32'h0000_0001, 1);
    repeat (3) @(posedge mclk_i);
    summarize();
  end
endmodule
